// file: logic/cpfe_regs.svh
/*
   Register map, field positions, reset values and timing counts of the camera port front end.
   Assumes a 250 MHz system clock and 32-bit AXI4-Lite register access.
*/
// Contract
// - Latch one data word per chosen pixel clock edge
// - Data word up to 16 differential bits
// - Four enables, each single-ended or differential
// - Trigger input starts acquisition on chosen edge
// - Trigger output driven to software level
// - Trigger output carries status or timed pulse
// - Master clock on two pairs, 500 kHz-40 MHz; the half period floor of 4 cycles limits the code to 31.25 MHz at most
// - Control outputs static or dynamic, single or differential
// - Control outputs produce exposure or shutter pulses
// - Pixel clock active edge rising or falling
// - Each enable has programmable active polarity
// - Pixel window measured from line enable assertion
`ifndef CPFE_REGS_SVH
`define CPFE_REGS_SVH

// Register byte offsets.
`define CPFE_OFS_CTRL     8'h00
`define CPFE_OFS_TRIG     8'h04
`define CPFE_OFS_PULSE    8'h08
`define CPFE_OFS_MCLK     8'h0C
`define CPFE_OFS_CTLOUT   8'h10
`define CPFE_OFS_WIN      8'h14
`define CPFE_OFS_STATUS   8'h18
`define CPFE_OFS_DATA     8'h1C
`define CPFE_OFS_CMD      8'h20

// Control register fields.
`define CPFE_CTRL_PCLK_FALL  0
`define CPFE_CTRL_PCLK_DIFF  1
`define CPFE_CTRL_CAP_EN     2
`define CPFE_CTRL_MCLK_DIFF  3
`define CPFE_CTRL_EN_POL     4
`define CPFE_CTRL_EN_DIFF    8

// Per-line byte fields of the trigger and control output registers.
`define CPFE_TRIG_FALL       0
`define CPFE_TRIG_START_EN   1
`define CPFE_TRIG_MODE       2
`define CPFE_TRIG_LEVEL      4
`define CPFE_CTL_DYNAMIC     0
`define CPFE_CTL_LEVEL       1
`define CPFE_CTL_DIFF        2

// Command register bits.
`define CPFE_CMD_START       0
`define CPFE_CMD_STOP        1

// Reset values.
`define CPFE_RST_CTRL        32'h0000_0004
`define CPFE_RST_TRIG        32'h0000_0000
`define CPFE_RST_PULSE       32'h0000_0005
`define CPFE_RST_MCLK        32'h0000_0004
`define CPFE_RST_CTLOUT      32'h0000_0000
`define CPFE_RST_WIN         32'hFFFF_0000

// Timing: clock rate, master clock range and least control pulse.
`define CPFE_CLK_KHZ         250000
`define CPFE_CLK_NS          4
`define CPFE_MCLK_MAX_KHZ    40000
`define CPFE_MCLK_MIN_KHZ    500
`define CPFE_CTL_MIN_NS      20
`define CPFE_MCLK_HALF_MIN   ((`CPFE_CLK_KHZ + 2 * `CPFE_MCLK_MAX_KHZ - 1) / (2 * `CPFE_MCLK_MAX_KHZ))
`define CPFE_MCLK_HALF_MAX   (`CPFE_CLK_KHZ / (2 * `CPFE_MCLK_MIN_KHZ))
`define CPFE_PULSE_MIN       ((`CPFE_CTL_MIN_NS + `CPFE_CLK_NS - 1) / `CPFE_CLK_NS)

`endif

// file: logic/cpfe_pkg.sv
/*
   Types of the camera port front end.
   Assumes the register header is compiled alongside.
*/
`default_nettype none

package cpfe_pkg;

   // Output modes of an external trigger line.
   typedef enum logic [1:0] {
      CPFE_TRIG_IN     = 2'b00,
      CPFE_TRIG_LVL    = 2'b01,
      CPFE_TRIG_STATUS = 2'b10,
      CPFE_TRIG_PULSE  = 2'b11
   } cpfe_trig_mode_t;

   // Whole state of the front end.
   typedef struct packed {
      logic        aw_have;
      logic [7:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] ctrl;
      logic [31:0] trig;
      logic [31:0] pulse;
      logic [31:0] mclk_half;
      logic [31:0] ctlout;
      logic [31:0] win;
      logic        pclk_q;
      logic [3:0]  en_q;
      logic [3:0]  trig_q;
      logic        acq;
      logic [15:0] pix_cnt;
      logic [31:0] pulse_cnt;
      logic [31:0] mclk_cnt;
      logic        mclk;
      logic [15:0] pix_data;
      logic        pix_valid;
      logic        pix_frame;
      logic        pix_line;
      logic        pix_field;
      logic [3:0]  trig_o;
      logic [3:0]  trig_oe;
      logic [3:0]  ctl_p;
      logic [3:0]  ctl_n;
   } cpfe_state_t;

endpackage

`default_nettype wire

// file: logic/cpfe_sync.sv
/*
   Three-stage synchroniser for a bus of pin levels.
   Assumes inputs arrive asynchronously to aclk.
*/
`default_nettype none

module cpfe_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Pin levels and filtered levels.
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } cpfe_sync_state_t;

   cpfe_sync_state_t st;
   cpfe_sync_state_t next_st;

   // A level is accepted once the second and third stages agree.
   always_comb
   begin
      next_st    = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.lvl[i] = st.s3[i];
         end
      end
      if (!aresetn)
      begin
         next_st = '0;
      end
   end

   // State register.
   always_ff @(posedge aclk)
   begin
      st <= next_st;
   end

   assign level = st.lvl;

endmodule

`default_nettype wire

// file: logic/cpfe_top.sv
/*
   Camera port front end: pixel capture, enables, triggers, control lines, master clock, AXI4-Lite slave.
   Assumes pad receivers deliver both legs of each pair as logic levels, and trigger pads are resolved outside.
*/
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`include "cpfe_regs.svh"
`default_nettype none

module cpfe_top #(
   parameter int DW = 16
) (
   // Clock and reset.
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // AXI4-Lite write channels.
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   output logic      [1:0]    s_axi_bresp,
   // AXI4-Lite read channels.
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   input  wire logic [7:0]    s_axi_araddr,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic      [31:0]   s_axi_rdata,
   output logic      [1:0]    s_axi_rresp,
   // Camera video inputs.
   input  wire logic [DW-1:0] vid_p,
   input  wire logic [DW-1:0] vid_n,
   input  wire logic          pclk_p,
   input  wire logic          pclk_n,
   input  wire logic [3:0]    en_p,
   input  wire logic [3:0]    en_n,
   // Camera outputs.
   output logic      [3:0]    ctl_p,
   output logic      [3:0]    ctl_n,
   output logic      [1:0]    mclk_p,
   output logic      [1:0]    mclk_n,
   // External trigger pins.
   input  wire logic [3:0]    trig_in,
   output logic      [3:0]    trig_out,
   output logic      [3:0]    trig_oe,
   // Captured pixel stream.
   output logic      [DW-1:0] pix_data,
   output logic               pix_valid,
   output logic               pix_frame,
   output logic               pix_line,
   output logic               pix_field
);

   cpfe_pkg::cpfe_state_t st;
   cpfe_pkg::cpfe_state_t next_st;

   logic [DW-1:0] vid_p_s;
   logic [DW-1:0] vid_n_s;
   logic          pclk_p_s;
   logic          pclk_n_s;
   logic [3:0]    en_p_s;
   logic [3:0]    en_n_s;
   logic [3:0]    trig_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Every pin passes the three-stage filter before any edge is looked for.
   cpfe_sync #(
      .W       (2 * DW + 2 + 8 + 4)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     ({vid_p, vid_n, pclk_p, pclk_n, en_p, en_n, trig_in}),
      .level   ({vid_p_s, vid_n_s, pclk_p_s, pclk_n_s, en_p_s, en_n_s, trig_s})
   );

   // Returns the received level of a pad, single-ended or differential.
   function automatic logic rx(input logic p, input logic n, input logic diff);
      rx = diff ? (p & ~n) : p;
   endfunction

   // Merges write data into a register under the byte strobes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            merge[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes accept a new request only while no response is pending.
   assign s_axi_awready = !st.aw_have && !st.bvalid;
   assign s_axi_wready  = !st.w_have && !st.bvalid;
   assign s_axi_arready = !st.rvalid;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state of the whole block.
   always_comb
   begin
      logic          sw_start;
      logic          sw_stop;
      logic          start;
      logic          pclk_lvl;
      logic          pclk_edge;
      logic [3:0]    en_act;
      logic [3:0]    trig_edge;
      logic [DW-1:0] vid;
      logic          in_win;
      logic          pulse_on;
      logic [31:0]   half;
      logic          lvl;
      cpfe_pkg::cpfe_trig_mode_t mode;
      sw_start  = 1'b0;
      sw_stop   = 1'b0;
      start     = 1'b0;
      pclk_lvl  = 1'b0;
      pclk_edge = 1'b0;
      en_act    = '0;
      trig_edge = '0;
      vid       = '0;
      in_win    = 1'b0;
      pulse_on  = 1'b0;
      half      = '0;
      lvl       = 1'b0;
      mode      = cpfe_pkg::CPFE_TRIG_IN;
      next_st   = st;

      // Register writes, once address and data are both held.
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_have = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_have = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.aw_have && st.w_have)
      begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = 2'h0;
         case (st.aw_addr)
            `CPFE_OFS_CTRL:   next_st.ctrl      = merge(st.ctrl, st.w_data, st.w_strb);
            `CPFE_OFS_TRIG:   next_st.trig      = merge(st.trig, st.w_data, st.w_strb);
            `CPFE_OFS_PULSE:  next_st.pulse     = merge(st.pulse, st.w_data, st.w_strb);
            `CPFE_OFS_MCLK:   next_st.mclk_half = merge(st.mclk_half, st.w_data, st.w_strb);
            `CPFE_OFS_CTLOUT: next_st.ctlout    = merge(st.ctlout, st.w_data, st.w_strb);
            `CPFE_OFS_WIN:    next_st.win       = merge(st.win, st.w_data, st.w_strb);
            `CPFE_OFS_STATUS, `CPFE_OFS_DATA: next_st.bresp = 2'h0;
            `CPFE_OFS_CMD:
            begin
               sw_start = st.w_strb[0] & st.w_data[`CPFE_CMD_START];
               sw_stop  = st.w_strb[0] & st.w_data[`CPFE_CMD_STOP];
            end
            default:          next_st.bresp     = 2'h2;
         endcase
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end

      // Register reads answer one cycle after the address is taken.
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = 2'h0;
         case (s_axi_araddr)
            `CPFE_OFS_CTRL:   next_st.rdata = st.ctrl;
            `CPFE_OFS_TRIG:   next_st.rdata = st.trig;
            `CPFE_OFS_PULSE:  next_st.rdata = st.pulse;
            `CPFE_OFS_MCLK:   next_st.rdata = st.mclk_half;
            `CPFE_OFS_CTLOUT: next_st.rdata = st.ctlout;
            `CPFE_OFS_WIN:    next_st.rdata = st.win;
            `CPFE_OFS_STATUS: next_st.rdata = {23'h0, st.acq, st.trig_q, st.en_q};
            `CPFE_OFS_DATA:   next_st.rdata = {{(32 - DW){1'b0}}, st.pix_data};
            `CPFE_OFS_CMD:    next_st.rdata = 32'h0;
            default:
            begin
               next_st.rdata = 32'h0;
               next_st.rresp = 2'h2;
            end
         endcase
      end

      // Received levels of enables and pixel clock, with chosen sense and polarity.
      for (int i = 0; i < 4; i++)
      begin
         en_act[i] = rx(en_p_s[i], en_n_s[i], st.ctrl[`CPFE_CTRL_EN_DIFF + i])
                     ^ st.ctrl[`CPFE_CTRL_EN_POL + i];
      end
      for (int i = 0; i < DW; i++)
      begin
         vid[i] = rx(vid_p_s[i], vid_n_s[i], 1'b1);
      end
      pclk_lvl  = rx(pclk_p_s, pclk_n_s, st.ctrl[`CPFE_CTRL_PCLK_DIFF]);
      pclk_edge = st.ctrl[`CPFE_CTRL_PCLK_FALL] ? (st.pclk_q & ~pclk_lvl)
                                                 : (~st.pclk_q & pclk_lvl);
      next_st.pclk_q = pclk_lvl;
      next_st.en_q   = en_act;

      // Pixel counter restarts at each line enable assertion.
      in_win = (st.pix_cnt >= st.win[15:0]) && ((st.pix_cnt - st.win[15:0]) < st.win[31:16]);
      if (!en_act[1])
      begin
         next_st.pix_cnt = '0;
      end
      else if (pclk_edge && st.pix_cnt != 16'hFFFF)
      begin
         next_st.pix_cnt = st.pix_cnt + 16'h1;
      end
      next_st.pix_valid = pclk_edge && st.acq && st.ctrl[`CPFE_CTRL_CAP_EN]
                          && en_act[0] && en_act[1] && in_win;
      if (pclk_edge)
      begin
         next_st.pix_data = vid;
      end
      next_st.pix_frame = en_act[0];
      next_st.pix_line  = en_act[1];
      next_st.pix_field = en_act[2];

      // Trigger edges start an acquisition on lines set as inputs.
      for (int i = 0; i < 4; i++)
      begin
         mode         = cpfe_pkg::cpfe_trig_mode_t'(st.trig[8*i + `CPFE_TRIG_MODE +: 2]);
         trig_edge[i] = st.trig[8*i + `CPFE_TRIG_FALL] ? (st.trig_q[i] & ~trig_s[i])
                                                        : (~st.trig_q[i] & trig_s[i]);
         if (trig_edge[i] && st.trig[8*i + `CPFE_TRIG_START_EN] && mode == cpfe_pkg::CPFE_TRIG_IN)
         begin
            start = 1'b1;
         end
      end
      next_st.trig_q = trig_s;
      start = start | sw_start;
      if (start)
      begin
         next_st.acq = 1'b1;
      end
      else if (sw_stop)
      begin
         next_st.acq = 1'b0;
      end

      // Timed pulse launched by each start, never shorter than the least control pulse.
      pulse_on = st.pulse_cnt != 32'h0;
      if (start)
      begin
         next_st.pulse_cnt = (st.pulse < 32'(`CPFE_PULSE_MIN)) ? 32'(`CPFE_PULSE_MIN) : st.pulse;
      end
      else if (pulse_on)
      begin
         next_st.pulse_cnt = st.pulse_cnt - 32'h1;
      end

      // Trigger outputs by mode.
      for (int i = 0; i < 4; i++)
      begin
         mode = cpfe_pkg::cpfe_trig_mode_t'(st.trig[8*i + `CPFE_TRIG_MODE +: 2]);
         next_st.trig_oe[i] = mode != cpfe_pkg::CPFE_TRIG_IN;
         case (mode)
            cpfe_pkg::CPFE_TRIG_LVL:    next_st.trig_o[i] = st.trig[8*i + `CPFE_TRIG_LEVEL];
            cpfe_pkg::CPFE_TRIG_STATUS: next_st.trig_o[i] = st.acq;
            cpfe_pkg::CPFE_TRIG_PULSE:  next_st.trig_o[i] = pulse_on;
            default:                    next_st.trig_o[i] = 1'b0;
         endcase
      end

      // Camera control lines: static level or pulse of active level.
      for (int i = 0; i < 4; i++)
      begin
         lvl = st.ctlout[8*i + `CPFE_CTL_LEVEL];
         if (st.ctlout[8*i + `CPFE_CTL_DYNAMIC])
         begin
            lvl = pulse_on ? lvl : ~lvl;
         end
         next_st.ctl_p[i] = lvl;
         next_st.ctl_n[i] = st.ctlout[8*i + `CPFE_CTL_DIFF] ? ~lvl : 1'b0;
      end

      // Master clock divider with half period held inside the legal range.
      half = st.mclk_half;
      if (half < 32'(`CPFE_MCLK_HALF_MIN))
      begin
         half = 32'(`CPFE_MCLK_HALF_MIN);
      end
      else if (half > 32'(`CPFE_MCLK_HALF_MAX))
      begin
         half = 32'(`CPFE_MCLK_HALF_MAX);
      end
      if (st.mclk_cnt >= half - 32'h1)
      begin
         next_st.mclk_cnt = '0;
         next_st.mclk     = ~st.mclk;
      end
      else
      begin
         next_st.mclk_cnt = st.mclk_cnt + 32'h1;
      end

      // Synchronous reset to constants.
      if (!aresetn)
      begin
         next_st           = '0;
         next_st.ctrl      = `CPFE_RST_CTRL;
         next_st.trig      = `CPFE_RST_TRIG;
         next_st.pulse     = `CPFE_RST_PULSE;
         next_st.mclk_half = `CPFE_RST_MCLK;
         next_st.ctlout    = `CPFE_RST_CTLOUT;
         next_st.win       = `CPFE_RST_WIN;
      end
   end

   // State register.
   always_ff @(posedge aclk)
   begin
      st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state.
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp  = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata  = st.rdata;
   assign s_axi_rresp  = st.rresp;
   assign pix_data     = st.pix_data;
   assign pix_valid    = st.pix_valid;
   assign pix_frame    = st.pix_frame;
   assign pix_line     = st.pix_line;
   assign pix_field    = st.pix_field;
   assign trig_out     = st.trig_o;
   assign trig_oe      = st.trig_oe;
   assign ctl_p        = st.ctl_p;
   assign ctl_n        = st.ctl_n;
   assign mclk_p       = {2{st.mclk}};
   assign mclk_n       = st.ctrl[`CPFE_CTRL_MCLK_DIFF] ? {2{~st.mclk}} : 2'b00;

endmodule

`default_nettype wire

// file: verif/cpfe_top_asserts.sv
/*
   Port checker of the camera port front end, bound into cpfe_top.
   Assumes the default data width and one clock domain on aclk.
*/
`default_nettype none

module cpfe_top_asserts (
   // Clock and reset.
   input wire logic       aclk,
   input wire logic       aresetn,
   // Register bus handshakes.
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   // Camera side and pixel stream.
   input wire logic [3:0] ctl_p,
   input wire logic [3:0] ctl_n,
   input wire logic [1:0] mclk_p,
   input wire logic [1:0] mclk_n,
   input wire logic       pix_valid,
   input wire logic       pix_frame,
   input wire logic       pix_line
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////
   // Bus handshakes hold and answer in time.
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");

   ////////////////////////////////////////
   // Pixel, master clock and control line relations.
   AST_PIX_PULSE: assert property (pix_valid |=> !pix_valid)
      else $error("pixel strobe longer than one cycle");
   AST_PIX_GATE: assert property (pix_valid |-> pix_frame && pix_line)
      else $error("pixel outside frame or line");
   AST_MCLK_PAIR: assert property (mclk_p[0] == mclk_p[1] && (mclk_n == 2'h0 || mclk_n == ~mclk_p))
      else $error("master clock pairs disagree");
   AST_MCLK_HALF: assert property ($changed(mclk_p[0]) |=> $stable(mclk_p[0]) [*3])
      else $error("master clock half period below four cycles");
   AST_CTL_DIFF: assert property ((ctl_p & ctl_n) == 4'h0)
      else $error("control pair legs both high");

   // Main scenarios reached.
   COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
   COV_READ: cover property (s_axi_rvalid && s_axi_rready);
   COV_PIX: cover property (pix_valid);
endmodule

bind cpfe_top cpfe_top_asserts u_chk (.*);

`default_nettype wire

// file: verif/cpfe_camera.sv
/*
   Camera model: frames of two lines of six pixels on a 125 ns pixel clock.
   Assumes the bench pulses go and waits on busy.
*/
`default_nettype none

module cpfe_camera (
   // Bench control.
   input  wire logic       go,
   input  wire logic       fall,
   input  wire logic [3:0] inv,
   output logic            busy,
   // Camera pins.
   output logic [15:0]     vid_p,
   output logic [15:0]     vid_n,
   output logic            pclk_p,
   output logic            pclk_n,
   output logic [3:0]      en_p,
   output logic [3:0]      en_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] d = 16'h0000;
   logic [3:0]  act = 4'h0;
   logic        c = 1'b0;

   // Pins; the clock rests at its inactive level between frames.
   assign pclk_p = c ^ fall;
   assign pclk_n = ~pclk_p;
   assign en_p = act ^ inv;
   assign en_n = ~en_p;
   assign vid_p = d;
   assign vid_n = ~d;

   // One frame per go; data settle half a period before the active edge.
   always @(posedge go)
   begin
      busy = 1'b1;
      act = 4'h1;
      #200;
      for (int l = 0; l < 2; l++)
      begin
         act[2] = l[0];
         act[1] = 1'b1;
         #100;
         for (int p = 0; p < 6; p++)
         begin
            d = 16'hA000 + 16'(l * 16 + p);
            #62.5 c = 1'b1;
            #62.5 c = 1'b0;
         end
         d = ~d;
         act[1] = 1'b0;
         #200;
      end
      act = 4'h0;
      #200 busy = 1'b0;
   end

   initial busy = 1'b0;
endmodule

`default_nettype wire

// file: verif/tb_top.sv
/*
   Self-checking bench of the camera port front end.
   Assumes the camera model and the bound checker are present.
*/
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, fall = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  inv = 4'h0, trig_in = 4'h0, trig_out, trig_oe, ctl_p, ctl_n, en_p, en_n;
   logic        awready, wready, bvalid, arready, rvalid, pclk_p, pclk_n, busy;
   logic        pix_valid, pix_frame, pix_line, pix_field;
   logic [1:0]  bresp, rresp, r, mclk_p, mclk_n;
   logic [31:0] rdata;
   logic [15:0] vid_p, vid_n, pix_data;
   logic [16:0] q [$];
   int          errors = 0, n_compared = 0, cyc = 0, nt, nc, n;

   cpfe_camera cam (.go(go), .fall(fall), .inv(inv), .busy(busy), .vid_p(vid_p), .vid_n(vid_n),
      .pclk_p(pclk_p), .pclk_n(pclk_n), .en_p(en_p), .en_n(en_n));

   cpfe_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .vid_p(vid_p), .vid_n(vid_n),
      .pclk_p(pclk_p), .pclk_n(pclk_n), .en_p(en_p), .en_n(en_n), .ctl_p(ctl_p), .ctl_n(ctl_n),
      .mclk_p(mclk_p), .mclk_n(mclk_n), .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe),
      .pix_data(pix_data), .pix_valid(pix_valid), .pix_frame(pix_frame), .pix_line(pix_line),
      .pix_field(pix_field));

   // Clock, timeout and stream monitor.
   always #2 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (pix_valid === 1'b1) q.push_back({pix_field, pix_data});
      if (trig_out[0] === 1'b1) nt++;
      if (ctl_p[0] === 1'b1) nc++;
      if (cyc == 40000)
      begin
         errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////
   // Counts comparisons and reports mismatches.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Bus write: address and data together, each dropped when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (awready === 1'b1 && !ad) begin ad = 1'b1; awvalid <= 1'b0; end
         if (wready === 1'b1 && !dd) begin dd = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk(32'(bresp), 32'(e));
   endtask

   // Bus read and check of data and response.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk(rdata, e);
      chk(32'(rresp), 32'(re));
   endtask

   task automatic wt(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic report_and_stop();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////
   // Main sequence.
   initial
   begin
      logic [31:0] rst [6] = '{32'h4, 32'h0, 32'h5, 32'h4, 32'h0, 32'hFFFF0000};
      int pw [2] = '{8, 3}, pe [2] = '{8, 5}, mv [3] = '{10, 2, 300}, me [3] = '{10, 4, 250};
      wt(12);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) rdchk(8'(4 * i), rst[i], 2'h0);
      rdchk(8'h24, 32'h0, 2'h2);
      wr(8'h24, 32'h1, 2'h2);
      // Trigger start on each edge choice, stop in between.
      wr(8'h04, 32'h3, 2'h0);
      trig_in <= 4'h1;
      wt(10);
      rdchk(8'h18, 32'h10, 2'h0);
      trig_in <= 4'h0;
      wt(10);
      rdchk(8'h18, 32'h100, 2'h0);
      wr(8'h20, 32'h2, 2'h0);
      wr(8'h04, 32'h2, 2'h0);
      trig_in <= 4'h1;
      wt(10);
      rdchk(8'h18, 32'h110, 2'h0);
      trig_in <= 4'h0;
      // Triggers as software levels.
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h04, 32'h14 << (8 * i), 2'h0);
         wt(3);
         chk(32'(trig_oe), 32'h1 << i);
         chk(32'(trig_out), 32'h1 << i);
         wr(8'h04, 32'h04 << (8 * i), 2'h0);
         wt(3);
         chk(32'(trig_out), 32'h0);
      end
      // Control lines static and pulsed, trigger pulse and status.
      wr(8'h10, 32'h0004_0203, 2'h0);
      wt(3);
      chk(32'(ctl_p), 32'h2);
      chk(32'(ctl_n), 32'h4);
      for (int i = 0; i < 2; i++)
      begin
         wr(8'h08, 32'(pw[i]), 2'h0);
         wr(8'h04, 32'h080C, 2'h0);
         wr(8'h20, 32'h2, 2'h0);
         wt(3);
         nt = 0;
         nc = 0;
         wr(8'h20, 32'h1, 2'h0);
         wt(40);
         chk(32'(nt), 32'(pe[i]));
         chk(32'(nc), 32'(pe[i]));
         chk(32'(trig_out[1]), 32'h1);
      end
      // Master clock half periods, including both clamps.
      wr(8'h00, 32'hC, 2'h0);
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h0C, 32'(mv[i]), 2'h0);
         repeat (2)
         begin
            r[0] = mclk_p[0];
            while (mclk_p[0] === r[0]) @(posedge aclk);
         end
         n = 0;
         r[0] = mclk_p[0];
         while (mclk_p[0] === r[0]) begin @(posedge aclk); n++; end
         chk(32'(n), 32'(me[i]));
      end
      // Video window on both clock edges and enable polarities.
      wr(8'h14, 32'h0003_0002, 2'h0);
      for (int i = 0; i < 2; i++)
      begin
         fall <= i[0];
         inv <= i[0] ? 4'h3 : 4'h0;
         wr(8'h00, i[0] ? 32'h35 : 32'h4, 2'h0);
         wr(8'h20, 32'h2, 2'h0);
         wr(8'h20, 32'h1, 2'h0);
         q.delete();
         go <= 1'b1;
         wt(1);
         go <= 1'b0;
         do @(posedge aclk); while (busy === 1'b1);
         wt(10);
         chk(32'(q.size()), 32'h6);
         for (int k = 0; k < 6; k++)
            chk(32'(q[k]), {15'h0, k > 2, 16'hA002 + 16'((k / 3) * 16 + k % 3)});
      end
      rdchk(8'h1C, 32'hA015, 2'h0);
      report_and_stop();
   end
endmodule

`default_nettype wire
